// *** rtcal_params.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RTCAL_PARAMS_SVH
`define RTCAL_PARAMS_SVH
`define RTCAL_OFS_WINDOW_HI 4'h0
`define RTCAL_OFS_WINDOW_LO 4'h1
`define RTCAL_OFS_CONFIG 4'h2
`define RTCAL_OFS_CAL 4'h3
`define RTCAL_OFS_STATUS 4'h4
`define RTCAL_CFG_EN 15
`define RTCAL_CFG_CHIME 14
`define RTCAL_CFG_MASK_HI 13
`define RTCAL_CFG_MASK_LO 10
`define RTCAL_CFG_PTR_HI 9
`define RTCAL_CFG_PTR_LO 8
`define RTCAL_CAL_WREN 15
`define RTCAL_CFG_RESET 16'h0000
`define RTCAL_MD_MASK 16'h1F3F
`define RTCAL_WH_MASK 16'h073F
`define RTCAL_MS_MASK 16'h7F7F
`define RTCAL_CAL_STEP 4
`define RTCAL_MINUTE_SEC 60
`define RTCAL_OSC_HZ 32768
`endif

// *** rtcal_pkg.sv ***
// types shared by the alarm and calibration block
package rtcal_pkg;
	typedef enum logic [3:0] {
		RTCAL_HALF_SEC, RTCAL_SEC, RTCAL_TEN_SEC, RTCAL_MIN, RTCAL_TEN_MIN,
		RTCAL_HOUR, RTCAL_DAY, RTCAL_WEEK, RTCAL_MONTH, RTCAL_YEAR
	} rtcal_mask_t;
	typedef logic [15:0] rtcal_word_t;
endpackage : rtcal_pkg

// *** rtcal_core.sv ***
// alarm compare, repeat counter and calibration pulse correction
//
// Contract
// RL1: month/day alarm fields in BCD layout
// RL2: weekday/hours alarm fields in BCD layout
// RL3: minutes/seconds alarm fields in BCD layout
// RL4: unused alarm bits read zero, ignore writes
// RL5: month/day, weekday/hours writes need write enable
// RL6: calibration value times four each minute
// RL7: negative removes pulses, positive adds pulses
// RL8: software changes calibration only when safe
// RL9: enable self-clears on final alarm
// RL10: software writes compare values while disabled
// RL11: four-bit mask selects alarm interval
// RL12: compare only digits the mask selects
// RL13: repeat counter decrements each alarm
// RL14: no chime, alarm at zero is last
// RL15: FFh gives 255 further repeats
// RL16: chime wraps counter and never disables
// RL17: alarm request on every alarm event
// RL18: pulse output toggles on each alarm
// RL19: software changes config while sync flag low
// RL20: software avoids reserved mask codes
// RL21: window pointer decrements on upper access
// RL22: pointer maps window to register pairs
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rtcal_params.svh"
module rtcal_core #(
	parameter int OSC_HZ = `RTCAL_OSC_HZ
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire rtcal_pkg::rtcal_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rtcal_pkg::rtcal_word_t reg_rdata,
	input wire logic half_sec_tick,
	input wire logic sec_tick,
	input wire logic clock_sync_flag,
	input wire rtcal_pkg::rtcal_word_t now_month_day,
	input wire rtcal_pkg::rtcal_word_t now_weekday_hours,
	input wire rtcal_pkg::rtcal_word_t now_minutes_seconds,
	output logic alarm_irq,
	output logic alarm_pulse,
	output logic cal_adjust,
	output logic signed [9:0] cal_pulses
);
	import rtcal_pkg::*;

	if (OSC_HZ < 1) begin : g_bad_osc
		$error("oscillator rate must be positive");
	end

	rtcal_word_t alarm_month_day_ff, nxt_alarm_month_day;
	rtcal_word_t alarm_weekday_hours_ff, nxt_alarm_weekday_hours;
	rtcal_word_t alarm_minutes_seconds_ff, nxt_alarm_minutes_seconds;
	logic alarm_enable_ff, nxt_alarm_enable;
	logic chime_ff, nxt_chime;
	logic [3:0] alarm_mask_ff, nxt_alarm_mask;
	logic [1:0] alarm_window_pointer_ff, nxt_alarm_window_pointer;
	logic [7:0] alarm_repeat_count_ff, nxt_alarm_repeat_count;
	logic clock_write_enable_ff, nxt_clock_write_enable;
	logic [7:0] cal_value_ff, nxt_cal_value;
	logic alarm_irq_ff, nxt_alarm_irq;
	logic alarm_pulse_ff, nxt_alarm_pulse;
	logic cal_adjust_ff, nxt_cal_adjust;
	logic signed [9:0] cal_pulses_ff, nxt_cal_pulses;
	logic [5:0] sec_cnt_ff, nxt_sec_cnt;
	rtcal_word_t rdata_ff, nxt_rdata;
	logic match;
	logic alarm_event;
	logic win_hi_acc;

	// selects one byte of the pair the pointer names
	function automatic logic [7:0] rtcal_window(input logic [1:0] ptr,
		input logic hi, input rtcal_word_t md, input rtcal_word_t wh,
		input rtcal_word_t ms);
		rtcal_word_t w;
		w = 16'h0000;
		unique case (ptr)
			2'h0: w = ms; // RL22
			2'h1: w = wh;
			2'h2: w = md;
			2'h3: w = 16'h0000;
		endcase
		return hi ? w[15:8] : w[7:0];
	endfunction : rtcal_window

	// digits selected by the mask must equal the current time
	always_comb begin
		logic sec1, sec10, min1, min10, hr, wd, dy, mo;
		sec1 = now_minutes_seconds[3:0] == alarm_minutes_seconds_ff[3:0];
		sec10 = now_minutes_seconds[6:4] == alarm_minutes_seconds_ff[6:4];
		min1 = now_minutes_seconds[11:8] == alarm_minutes_seconds_ff[11:8];
		min10 = now_minutes_seconds[14:12] == alarm_minutes_seconds_ff[14:12];
		hr = now_weekday_hours[5:0] == alarm_weekday_hours_ff[5:0];
		wd = now_weekday_hours[10:8] == alarm_weekday_hours_ff[10:8];
		dy = now_month_day[5:0] == alarm_month_day_ff[5:0];
		mo = now_month_day[12:8] == alarm_month_day_ff[12:8];
		match = 1'b0;
		unique case (alarm_mask_ff) // RL11 RL12
			4'h0: match = half_sec_tick;
			4'h1: match = sec_tick;
			4'h2: match = sec_tick & sec1;
			4'h3: match = sec_tick & sec1 & sec10;
			4'h4: match = sec_tick & sec1 & sec10 & min1;
			4'h5: match = sec_tick & sec1 & sec10 & min1 & min10;
			4'h6: match = sec_tick & sec1 & sec10 & min1 & min10 & hr;
			4'h7: match = sec_tick & sec1 & sec10 & min1 & min10 & hr & wd;
			4'h8: match = sec_tick & sec1 & sec10 & min1 & min10 & hr & dy;
			4'h9: match = sec_tick & sec1 & sec10 & min1 & min10 & hr & dy
				& mo;
			// reserved codes never fire rather than guess an interval
			default: match = 1'b0;
		endcase
	end

	assign alarm_event = alarm_enable_ff & match;
	assign win_hi_acc = (reg_wr | reg_rd) &
		(reg_addr == `RTCAL_OFS_WINDOW_HI);

	always_comb begin
		logic [7:0] b;
		logic wr_hi, wr_lo, wr_cfg;
		b = reg_wdata[7:0];
		wr_hi = reg_wr & (reg_addr == `RTCAL_OFS_WINDOW_HI);
		wr_lo = reg_wr & (reg_addr == `RTCAL_OFS_WINDOW_LO);
		wr_cfg = reg_wr & (reg_addr == `RTCAL_OFS_CONFIG);
		nxt_alarm_month_day = alarm_month_day_ff;
		nxt_alarm_weekday_hours = alarm_weekday_hours_ff;
		nxt_alarm_minutes_seconds = alarm_minutes_seconds_ff;
		nxt_alarm_enable = alarm_enable_ff;
		nxt_chime = chime_ff;
		nxt_alarm_mask = alarm_mask_ff;
		nxt_alarm_window_pointer = alarm_window_pointer_ff;
		nxt_alarm_repeat_count = alarm_repeat_count_ff;
		nxt_clock_write_enable = clock_write_enable_ff;
		nxt_cal_value = cal_value_ff;
		if (wr_hi | wr_lo) begin
			unique case (alarm_window_pointer_ff)
				2'h0: begin
					if (wr_hi) begin
						nxt_alarm_minutes_seconds[15:8] = b & 8'h7F; // RL3 RL4
					end else begin
						nxt_alarm_minutes_seconds[7:0] = b & 8'h7F; // RL3 RL4
					end
				end
				2'h1: begin
					if (clock_write_enable_ff && wr_hi) begin // RL5
						nxt_alarm_weekday_hours[15:8] = b & 8'h07; // RL2 RL4
					end else if (clock_write_enable_ff) begin
						nxt_alarm_weekday_hours[7:0] = b & 8'h3F; // RL2 RL4
					end
				end
				2'h2: begin
					if (clock_write_enable_ff && wr_hi) begin // RL5
						nxt_alarm_month_day[15:8] = b & 8'h1F; // RL1 RL4
					end else if (clock_write_enable_ff) begin
						nxt_alarm_month_day[7:0] = b & 8'h3F; // RL1 RL4
					end
				end
				2'h3: begin
				end
			endcase
		end
		if (win_hi_acc && alarm_window_pointer_ff != 2'h0) begin
			nxt_alarm_window_pointer = alarm_window_pointer_ff - 2'h1; // RL21
		end
		if (wr_cfg) begin
			nxt_alarm_enable = reg_wdata[`RTCAL_CFG_EN];
			nxt_chime = reg_wdata[`RTCAL_CFG_CHIME];
			nxt_alarm_mask = reg_wdata[`RTCAL_CFG_MASK_HI:`RTCAL_CFG_MASK_LO];
			nxt_alarm_window_pointer =
				reg_wdata[`RTCAL_CFG_PTR_HI:`RTCAL_CFG_PTR_LO];
			nxt_alarm_repeat_count = reg_wdata[7:0];
		end
		if (reg_wr && reg_addr == `RTCAL_OFS_CAL) begin
			nxt_clock_write_enable = reg_wdata[`RTCAL_CAL_WREN];
			nxt_cal_value = reg_wdata[7:0];
		end
		// hardware event wins over a same-cycle config write
		if (alarm_event) begin
			nxt_alarm_repeat_count = alarm_repeat_count_ff - 8'h01; // RL13 RL16
			if (!chime_ff && alarm_repeat_count_ff == 8'h00) begin
				nxt_alarm_repeat_count = 8'h00; // RL14
				nxt_alarm_enable = 1'b0; // RL9 RL14 RL15
			end
		end
	end

	// minute pacing and the calibration correction pulse
	always_comb begin
		nxt_sec_cnt = sec_cnt_ff;
		nxt_cal_adjust = 1'b0;
		nxt_cal_pulses = cal_pulses_ff;
		if (sec_tick) begin
			if (sec_cnt_ff == 6'(`RTCAL_MINUTE_SEC - 1)) begin
				nxt_sec_cnt = 6'h00;
				nxt_cal_adjust = 1'b1; // RL6
				// sign kept: negative removes, positive adds
				nxt_cal_pulses = 10'($signed(cal_value_ff)) *
					10'sd`RTCAL_CAL_STEP; // RL6 RL7
			end else begin
				nxt_sec_cnt = sec_cnt_ff + 6'h01;
			end
		end
		nxt_alarm_irq = alarm_event; // RL17
		nxt_alarm_pulse = alarm_pulse_ff ^ alarm_event; // RL18
	end

	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				`RTCAL_OFS_WINDOW_HI: nxt_rdata = {8'h00, rtcal_window(
					alarm_window_pointer_ff, 1'b1, alarm_month_day_ff,
					alarm_weekday_hours_ff, alarm_minutes_seconds_ff)};
				`RTCAL_OFS_WINDOW_LO: nxt_rdata = {8'h00, rtcal_window(
					alarm_window_pointer_ff, 1'b0, alarm_month_day_ff,
					alarm_weekday_hours_ff, alarm_minutes_seconds_ff)};
				`RTCAL_OFS_CONFIG: nxt_rdata = {alarm_enable_ff, chime_ff,
					alarm_mask_ff, alarm_window_pointer_ff,
					alarm_repeat_count_ff};
				`RTCAL_OFS_CAL: nxt_rdata = {clock_write_enable_ff, 7'h00,
					cal_value_ff};
				`RTCAL_OFS_STATUS: nxt_rdata = {14'h0000, clock_sync_flag,
					alarm_pulse_ff};
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end

	// low clock enable freezes every register, read data too
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			alarm_month_day_ff <= 16'h0000;
			alarm_weekday_hours_ff <= 16'h0000;
			alarm_minutes_seconds_ff <= 16'h0000;
			alarm_enable_ff <= 1'b0;
			chime_ff <= 1'b0;
			alarm_mask_ff <= 4'h0;
			alarm_window_pointer_ff <= 2'h0;
			alarm_repeat_count_ff <= 8'h00;
			clock_write_enable_ff <= 1'b0;
			cal_value_ff <= 8'h00;
			alarm_irq_ff <= 1'b0;
			alarm_pulse_ff <= 1'b0;
			cal_adjust_ff <= 1'b0;
			cal_pulses_ff <= 10'sh000;
			sec_cnt_ff <= 6'h00;
			rdata_ff <= 16'h0000;
		end else if (clk_en) begin
			alarm_month_day_ff <= nxt_alarm_month_day;
			alarm_weekday_hours_ff <= nxt_alarm_weekday_hours;
			alarm_minutes_seconds_ff <= nxt_alarm_minutes_seconds;
			alarm_enable_ff <= nxt_alarm_enable;
			chime_ff <= nxt_chime;
			alarm_mask_ff <= nxt_alarm_mask;
			alarm_window_pointer_ff <= nxt_alarm_window_pointer;
			alarm_repeat_count_ff <= nxt_alarm_repeat_count;
			clock_write_enable_ff <= nxt_clock_write_enable;
			cal_value_ff <= nxt_cal_value;
			alarm_irq_ff <= nxt_alarm_irq;
			alarm_pulse_ff <= nxt_alarm_pulse;
			cal_adjust_ff <= nxt_cal_adjust;
			cal_pulses_ff <= nxt_cal_pulses;
			sec_cnt_ff <= nxt_sec_cnt;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign alarm_irq = alarm_irq_ff;
	assign alarm_pulse = alarm_pulse_ff;
	assign cal_adjust = cal_adjust_ff;
	assign cal_pulses = cal_pulses_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_last_alarm;
		clk_en && alarm_event && !chime_ff && alarm_repeat_count_ff == 8'h00;
	endsequence
	sequence s_disabled;
		!alarm_enable_ff && alarm_repeat_count_ff == 8'h00;
	endsequence

	a_last_alarm_off: assert property (s_last_alarm |=> s_disabled) // RL9
		else $error("enable not cleared after final alarm");
	a_repeat_dec: assert property (clk_en && alarm_event &&
		(chime_ff || alarm_repeat_count_ff != 8'h00) |=>
		alarm_repeat_count_ff == $past(alarm_repeat_count_ff) - 8'h01) // RL13
		else $error("repeat count did not step down");
	a_chime_wrap: assert property (clk_en && alarm_event && chime_ff &&
		alarm_repeat_count_ff == 8'h00 && !(reg_wr &&
		reg_addr == `RTCAL_OFS_CONFIG) |=>
		alarm_repeat_count_ff == 8'hFF && alarm_enable_ff) // RL16
		else $error("chime did not wrap");
	a_irq_event: assert property (clk_en |=>
		alarm_irq == $past(alarm_event)) // RL17
		else $error("alarm request mismatch");
	a_pulse_toggle: assert property (clk_en && alarm_event |=>
		alarm_pulse != $past(alarm_pulse)) // RL18
		else $error("alarm pulse did not toggle");
	a_ptr_step: assert property (clk_en && win_hi_acc && !reg_wr |->
		alarm_window_pointer_ff == 2'h0 ##1
		alarm_window_pointer_ff == 2'h0 or
		alarm_window_pointer_ff != 2'h0 ##1 alarm_window_pointer_ff ==
		$past(alarm_window_pointer_ff) - 2'h1) // RL21
		else $error("window pointer step wrong");
	a_wren_guard: assert property (clk_en && !clock_write_enable_ff &&
		!alarm_event |=> $stable(alarm_month_day_ff) &&
		$stable(alarm_weekday_hours_ff)) // RL5
		else $error("alarm date written without enable");
	a_unused_zero: assert property ((alarm_month_day_ff &
		~`RTCAL_MD_MASK) == 16'h0000 && (alarm_weekday_hours_ff &
		~`RTCAL_WH_MASK) == 16'h0000 && (alarm_minutes_seconds_ff &
		~`RTCAL_MS_MASK) == 16'h0000) // RL4
		else $error("unused alarm bits set");
	a_cal_times4: assert property (clk_en && nxt_cal_adjust |=>
		cal_adjust && cal_pulses == 10'($signed($past(cal_value_ff))) *
		10'sd4) // RL6 RL7
		else $error("calibration scaling wrong");

	a_win_unmapped: assert property (clk_en && reg_rd &&
		alarm_window_pointer_ff == 2'h3 &&
		(reg_addr == `RTCAL_OFS_WINDOW_HI ||
		reg_addr == `RTCAL_OFS_WINDOW_LO) |=> reg_rdata == 16'h0000) // RL22
		else $error("unmapped window pair read nonzero");
	a_md_write: assert property (clk_en && reg_wr &&
		clock_write_enable_ff && alarm_window_pointer_ff == 2'h2 &&
		reg_addr == `RTCAL_OFS_WINDOW_LO |=> alarm_month_day_ff[7:0] ==
		($past(reg_wdata[7:0]) & 8'h3F)) // RL1
		else $error("enabled day write lost");
	a_cal_hold: assert property (clk_en && !nxt_cal_adjust |=>
		!cal_adjust && $stable(cal_pulses)) // RL6
		else $error("calibration output moved off the minute");
	a_pulse_hold: assert property (!(clk_en && alarm_event) |=>
		$stable(alarm_pulse)) // RL18
		else $error("alarm pulse moved without an event");
endmodule : rtcal_core

// *** rtcal_core_tb.sv ***
// self-checking bench for the alarm and calibration block
`timescale 1ns/1ps
`include "rtcal_params.svh"
module rtcal_core_tb;
	import rtcal_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	rtcal_word_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	rtcal_word_t reg_rdata;
	logic half_sec_tick = 1'b0;
	logic sec_tick = 1'b0;
	logic clock_sync_flag = 1'b0;
	rtcal_word_t now_md = 16'h0000;
	rtcal_word_t now_wh = 16'h0000;
	rtcal_word_t now_ms = 16'h0000;
	logic alarm_irq;
	logic alarm_pulse;
	logic cal_adjust;
	logic signed [9:0] cal_pulses;
	int n_mismatch = 0;
	int total_checks = 0;
	rtcal_word_t al [3];
	rtcal_word_t rv;
	logic exp_pulse = 1'b0;
	rtcal_core u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .half_sec_tick(half_sec_tick),
		.sec_tick(sec_tick), .clock_sync_flag(clock_sync_flag),
		.now_month_day(now_md), .now_weekday_hours(now_wh),
		.now_minutes_seconds(now_ms), .alarm_irq(alarm_irq),
		.alarm_pulse(alarm_pulse), .cal_adjust(cal_adjust),
		.cal_pulses(cal_pulses));
	always #25 clk_sys = ~clk_sys;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input rtcal_word_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output rtcal_word_t d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic tick(input logic h, input logic s);
		@(posedge clk_sys);
		half_sec_tick <= h;
		sec_tick <= s;
		@(posedge clk_sys);
		half_sec_tick <= 1'b0;
		sec_tick <= 1'b0;
		#1;
	endtask : tick
	function automatic rtcal_word_t cfg(input logic en, input logic ch,
		input logic [3:0] m, input logic [7:0] c);
		return {en, ch, m, 2'b00, c};
	endfunction : cfg
	function automatic rtcal_word_t wmask(input int p);
		return p == 0 ? `RTCAL_MS_MASK :
			p == 1 ? `RTCAL_WH_MASK : `RTCAL_MD_MASK;
	endfunction : wmask
	// low half first, the high access moves the pointer down
	task automatic load_window(input logic wren);
		rtcal_word_t v;
		wr(`RTCAL_OFS_CONFIG, 16'h0200);
		for (int p = 2; p >= 0; p--) begin
			v = 16'($urandom);
			if (wren || p == 0) al[p] = v & wmask(p);
			wr(`RTCAL_OFS_WINDOW_LO, {8'h00, v[7:0]});
			wr(`RTCAL_OFS_WINDOW_HI, {8'h00, v[15:8]});
		end
		rd(`RTCAL_OFS_CONFIG, rv);
		check(rv, 16'h0000);
		wr(`RTCAL_OFS_CONFIG, 16'h0200);
		for (int p = 2; p >= 0; p--) begin
			rd(`RTCAL_OFS_WINDOW_LO, rv);
			check(rv, {8'h00, al[p][7:0]});
			rd(`RTCAL_OFS_WINDOW_HI, rv);
			check(rv, {8'h00, al[p][15:8]});
		end
	endtask : load_window
	task automatic step(input logic h, input logic s, input logic f,
		input rtcal_word_t c);
		tick(h, s);
		check({15'h0, alarm_irq}, {15'h0, f});
		exp_pulse = exp_pulse ^ f;
		check({15'h0, alarm_pulse}, {15'h0, exp_pulse});
		rd(`RTCAL_OFS_CONFIG, rv);
		check(rv, c);
	endtask : step
	task automatic set_now(input rtcal_word_t md, input rtcal_word_t wh,
		input rtcal_word_t ms);
		@(posedge clk_sys);
		now_md <= md;
		now_wh <= wh;
		now_ms <= ms;
	endtask : set_now
	// hunt for the first minute mark, its phase is free-running
	task automatic cal_run;
		logic found;
		logic [7:0] c;
		found = 1'b0;
		wr(`RTCAL_OFS_CONFIG, 16'h0000);
		tick(1'b0, 1'b1);
		wr(`RTCAL_OFS_CAL, 16'h80FD);
		for (int i = 0; i < 61 && !found; i++) begin
			tick(1'b0, 1'b1);
			found = cal_adjust;
		end
		check({15'h0, found}, 16'h0001);
		if (found) begin
			check({6'h00, cal_pulses}, 16'h03F4);
			c = 8'($urandom);
			wr(`RTCAL_OFS_CAL, {8'h80, c});
			for (int i = 0; i < 60; i++) begin
				tick(1'b0, 1'b1);
				check({15'h0, cal_adjust}, {15'h0, i == 59});
			end
			check({6'h00, cal_pulses}, {6'h00, c[7], c[7], c, 2'b00});
		end
	endtask : cal_run
	task automatic finish_test;
		$display("mismatches %0d, checks %0d", n_mismatch, total_checks);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	initial begin
		void'($urandom(39));
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(`RTCAL_OFS_CONFIG, rv);
		check(rv, `RTCAL_CFG_RESET);
		rd(4'h7, rv);
		check(rv, 16'h0000);
		wr(`RTCAL_OFS_CAL, 16'h8000);
		load_window(1'b1);
		// write enable low: only minutes/seconds may change
		wr(`RTCAL_OFS_CAL, 16'h0000);
		load_window(1'b0);
		// pointer 3 names no pair: reads zero, still steps down
		wr(`RTCAL_OFS_CONFIG, 16'h0300);
		rd(`RTCAL_OFS_WINDOW_HI, rv);
		check(rv, 16'h0000);
		rd(`RTCAL_OFS_CONFIG, rv);
		check(rv, 16'h0200);
		set_now(al[2], al[1], al[0]);
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b0, 4'h1, 8'h02));
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b0, 4'h1, 8'h01));
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b0, 4'h1, 8'h00));
		step(1'b0, 1'b1, 1'b1, cfg(1'b0, 1'b0, 4'h1, 8'h00));
		step(1'b0, 1'b1, 1'b0, cfg(1'b0, 1'b0, 4'h1, 8'h00));
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b0, 4'h1, 8'hFF));
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b0, 4'h1, 8'hFE));
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h1, 8'h00));
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b1, 4'h1, 8'hFF));
		// every defined mask code with a full match
		for (int m = 0; m < 10; m++) begin
			wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, m[3:0], 8'h05));
			step(m == 0, m != 0, 1'b1,
				cfg(1'b1, 1'b1, m[3:0], 8'h04));
		end
		// clock enable low: a matching second leaves no trace
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h1, 8'h05));
		@(posedge clk_sys);
		clk_en <= 1'b0;
		tick(1'b0, 1'b1);
		check({15'h0, alarm_irq}, 16'h0000);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		step(1'b0, 1'b0, 1'b0, cfg(1'b1, 1'b1, 4'h1, 8'h05));
		// minutes ignored by the minute mask, second tens are not
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h3, 8'h05));
		set_now(al[2], al[1], al[0] ^ 16'h0100);
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b1, 4'h3, 8'h04));
		set_now(al[2], al[1], al[0] ^ 16'h0010);
		step(1'b0, 1'b1, 1'b0, cfg(1'b1, 1'b1, 4'h3, 8'h04));
		// weekday checked weekly only; month checked yearly only
		set_now(al[2] ^ 16'h0100, al[1] ^ 16'h0100, al[0]);
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h7, 8'h05));
		step(1'b0, 1'b1, 1'b0, cfg(1'b1, 1'b1, 4'h7, 8'h05));
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h8, 8'h05));
		step(1'b0, 1'b1, 1'b1, cfg(1'b1, 1'b1, 4'h8, 8'h04));
		wr(`RTCAL_OFS_CONFIG, cfg(1'b1, 1'b1, 4'h9, 8'h05));
		step(1'b0, 1'b1, 1'b0, cfg(1'b1, 1'b1, 4'h9, 8'h05));
		@(posedge clk_sys);
		clock_sync_flag <= 1'b1;
		rd(`RTCAL_OFS_STATUS, rv);
		check(rv, {14'h0, 1'b1, exp_pulse});
		@(posedge clk_sys);
		clock_sync_flag <= 1'b0;
		cal_run();
		finish_test();
	end
endmodule : rtcal_core_tb
